// *** cpch_params.svh ***
// Offsets, field positions, codes, limits and reset values of the cyclic position command handler.
// Assumes word addressing on the register bus; frames arrive as 32 bytes, byte n at bits 8n+7:8n.
// How it works
// - Long frame bytes 16-31 carry sub-command fields.
// - Command 2h in closed-loop, servo on: position.
// - Single-turn absolute out of range answers 0033h.
// - Held command position is regained at servo-on.
// - Idle command keeps the previous command position.
// - Per-period change above limit raises protection 27.4.
// - Change above 7FFFFFFh is handled by wraparound.
// - Incremental mode: homing before positioning after reset.
// - Cyclic homing by host, profile homing by drive.
// - No homing in velocity/torque, except multi-turn clear.
// - Checksum failure answers FFh, keeps last command.
`ifndef CPCH_PARAMS_SVH
`define CPCH_PARAMS_SVH
`define CPCH_OFS_CTRL 3'h0
`define CPCH_OFS_STATUS 3'h1
`define CPCH_OFS_LIMIT 3'h2
`define CPCH_OFS_RMIN 3'h3
`define CPCH_OFS_RMAX 3'h4
`define CPCH_OFS_COMMANDED_POSITION 3'h5
`define CPCH_OFS_LERR 3'h6
`define CPCH_BIT_PROFILE 2
`define CPCH_BIT_INCR 3
`define CPCH_BIT_STABS 4
`define CPCH_BIT_LONG 5
`define CPCH_BIT_SRST 6
`define CPCH_BIT_PVAL 7
`define CPCH_RST_CTRL 32'h00000000
`define CPCH_RST_LIMIT 32'h00100000
`define CPCH_RST_RMIN 32'h00000000
`define CPCH_RST_RMAX 32'h000FFFFF
`define CPCH_CYC_IDLE 3'h0
`define CPCH_CYC_POS 3'h2
`define CPCH_CODE_HOME 7'h24
`define CPCH_TYPE_MTCLR 8'h31
`define CPCH_RSP_COMM 8'hFF
`define CPCH_SUB_HDR_COMM 8'h8F
`define CPCH_ERR_NONE 16'h0000
`define CPCH_ERR_RANGE 16'h0033
`define CPCH_ERR_MOVE 16'h0274
`define CPCH_ERR_HOME 16'h0010
`define CPCH_ERR_NOHOME 16'h0011
`define CPCH_WRAP_LIMIT 32'h07FFFFFF
`endif

// *** cpch_pkg.sv ***
// Types shared by the cyclic position command handler.
// Assumes cpch_params.svh is compiled alongside.
package cpch_pkg;
    typedef enum logic [1:0] {
        CPCH_ST_WAIT = 2'b00,
        CPCH_ST_EVAL = 2'b01,
        CPCH_ST_REPLY = 2'b11
    } cpch_state_t;
    typedef enum logic [1:0] {
        CPCH_MODE_SEMI = 2'b00,
        CPCH_MODE_FULL = 2'b01,
        CPCH_MODE_VEL = 2'b10,
        CPCH_MODE_TRQ = 2'b11
    } cpch_mode_t;
    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic [7:0] sub_type;
        logic [15:0] index;
        logic [31:0] sub_request_word1;
        logic [31:0] sub_request_word2;
        logic [31:0] sub_request_word3;
    } cpch_sub_t;
    typedef struct packed {
        logic [2:0] cyc;
        logic [6:0] code;
        logic [31:0] commanded_position;
        logic [7:0] type_code;
        cpch_sub_t sub;
    } cpch_cmd_t;
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] err;
        logic [31:0] actual_position;
        logic [7:0] sub_hdr;
    } cpch_reply_t;
    function automatic logic [31:0] cpch_mag(input logic [31:0] v);
        return v[31] ? 32'(~v + 32'h00000001) : v;
    endfunction : cpch_mag
endpackage : cpch_pkg

// *** cpch_frame_decode.sv ***
// Combinational split of a received command frame into fields.
// Assumes a frame already checked for length; checksum is judged outside.
`timescale 1ns/1ns
`default_nettype none
module cpch_frame_decode
    import cpch_pkg::*;
(
    // Frame
    input wire logic [255:0] frame,
    input wire logic long_frame,
    // Fields
    output cpch_cmd_t cmd
);
    function automatic logic [31:0] le32(input logic [255:0] f, input int b);
        return f[8*b +: 32];
    endfunction : le32

    always_comb begin
        cmd.cyc = frame[14:12];
        cmd.code = frame[14:8];
        cmd.commanded_position = le32(frame, 4);
        cmd.type_code = frame[71:64];
        // Check bit set and bits 6-4 clear mark a sub-command
        cmd.sub.valid = long_frame && frame[135] && (frame[134:132] == 3'h0);
        cmd.sub.code = frame[131:128];
        cmd.sub.sub_type = frame[143:136];
        cmd.sub.index = frame[159:144];
        cmd.sub.sub_request_word1 = le32(frame, 20);
        cmd.sub.sub_request_word2 = le32(frame, 24);
        cmd.sub.sub_request_word3 = le32(frame, 28);
    end
endmodule : cpch_frame_decode
`default_nettype wire

// *** cpch_move_check.sv ***
// Per-period movement of the commanded position against the limit.
// Assumes previous and new positions are 32-bit two's complement.
`timescale 1ns/1ns
`default_nettype none
`include "cpch_params.svh"
module cpch_move_check
    import cpch_pkg::*;
(
    // Positions
    input wire logic [31:0] new_pos,
    input wire logic [31:0] prev_pos,
    input wire logic [31:0] limit,
    // Result
    output logic [31:0] delta,
    output logic over_limit,
    output logic wrap
);
    logic [31:0] mag;

    always_comb begin
        delta = 32'(new_pos - prev_pos);
        mag = cpch_mag(delta);
        over_limit = mag > limit;
        wrap = mag > `CPCH_WRAP_LIMIT;
    end
endmodule : cpch_move_check
`default_nettype wire

// *** cpch_handler.sv ***
// Top of the cyclic position command handler: frame evaluation, target position, homing gate, registers.
// Assumes frames, servo state and homing engine run on ref_clk; the bus master is Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "cpch_params.svh"
module cpch_handler
    import cpch_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Received frames
    input wire logic frame_valid,
    input wire logic frame_crc_ok,
    input wire logic [255:0] frame_data,
    // Drive state
    input wire logic servo_active,
    input wire logic [31:0] actual_position,
    input wire logic homing_complete,
    // Reply
    output logic reply_valid,
    output cpch_reply_t reply,
    // Motion
    output logic [31:0] target_position,
    output logic position_enable,
    output logic homing_start,
    output logic homing_profile,
    output logic multiturn_clear,
    // Sub-command
    output logic sub_valid,
    output cpch_sub_t sub_request
);
    cpch_state_t state;
    cpch_state_t next_state;
    cpch_cmd_t dec_cmd;
    cpch_cmd_t cmd_q;
    logic crc_q;
    logic [31:0] ctrl;
    logic [31:0] move_limit;
    logic [31:0] range_min;
    logic [31:0] range_max;
    logic [31:0] prev_cmd;
    logic [15:0] last_err;
    logic homed;
    logic home_busy;
    logic st_move;
    logic st_wrap;
    logic st_range;
    logic st_crc;
    logic st_refuse;
    logic ack;
    logic [31:0] delta;
    logic over_limit;
    logic wrap;
    cpch_mode_t mode;
    logic pos_mode;
    logic incremental;
    logic eval;
    logic is_home;
    logic take;
    logic range_bad;
    logic home_gate_ok;
    logic refuse;
    logic mt_req;
    logic home_req;
    logic ev_move;
    logic ev_range;
    logic ev_crc;
    logic bus_wr;
    logic soft_clear;

    cpch_frame_decode u_decode (
        .frame(frame_data),
        .long_frame(ctrl[`CPCH_BIT_LONG]),
        .cmd(dec_cmd)
    );

    cpch_move_check u_move (
        .new_pos(cmd_q.commanded_position),
        .prev_pos(prev_cmd),
        .limit(move_limit),
        .delta(delta),
        .over_limit(over_limit),
        .wrap(wrap)
    );

    always_comb begin
        mode = cpch_mode_t'(ctrl[1:0]);
        pos_mode = (mode == CPCH_MODE_SEMI) || (mode == CPCH_MODE_FULL);
        incremental = ctrl[`CPCH_BIT_INCR];
        eval = state == CPCH_ST_EVAL;
        is_home = cmd_q.code == `CPCH_CODE_HOME;
        // Velocity/torque only allow the multi-turn clear
        mt_req = eval && crc_q && is_home && !pos_mode && (cmd_q.type_code == `CPCH_TYPE_MTCLR);
        refuse = eval && crc_q && is_home && !pos_mode && (cmd_q.type_code != `CPCH_TYPE_MTCLR);
        home_req = eval && crc_q && is_home && pos_mode && !home_busy;
        // Homing frames themselves carry the host trajectory in cyclic homing
        home_gate_ok = homed || !incremental || (is_home && !ctrl[`CPCH_BIT_PROFILE]);
        // Latched even with servo off so the held target is regained at servo-on
        take = eval && crc_q && (cmd_q.cyc == `CPCH_CYC_POS) && pos_mode && home_gate_ok;
        range_bad = ctrl[`CPCH_BIT_STABS]
            && (($signed(cmd_q.commanded_position) < $signed(range_min))
            || ($signed(cmd_q.commanded_position) > $signed(range_max)));
        ev_range = take && range_bad;
        ev_move = take && !range_bad && over_limit;
        ev_crc = eval && !crc_q;
        bus_wr = avs_write && ack;
        soft_clear = bus_wr && (avs_address == `CPCH_OFS_CTRL)
            && (avs_writedata[`CPCH_BIT_SRST] || avs_writedata[`CPCH_BIT_PVAL]);
    end

    // Frame state machine
    always_comb begin
        case (state)
            CPCH_ST_WAIT: next_state = frame_valid ? CPCH_ST_EVAL : CPCH_ST_WAIT;
            CPCH_ST_EVAL: next_state = CPCH_ST_REPLY;
            CPCH_ST_REPLY: next_state = CPCH_ST_WAIT;
            default: next_state = CPCH_ST_WAIT;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= CPCH_ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // Frames arriving outside WAIT are dropped; one reply per taken frame
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmd_q <= '0;
            crc_q <= 1'b0;
        end else if (state == CPCH_ST_WAIT && frame_valid) begin
            cmd_q <= dec_cmd;
            crc_q <= frame_crc_ok;
        end
    end

    // Target position and movement history
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            target_position <= 32'h00000000;
            prev_cmd <= 32'h00000000;
        end else if (take && !range_bad) begin
            prev_cmd <= cmd_q.commanded_position;
            if (!over_limit) begin
                // Modular sum keeps large steps continuous across the wrap
                target_position <= 32'(target_position + delta);
            end
        end
    end
    // Idle and bad-checksum frames leave target untouched

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            position_enable <= 1'b0;
        end else begin
            position_enable <= servo_active && pos_mode && (homed || !incremental || home_busy);
        end
    end

    // Homing control
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            homed <= 1'b0;
            home_busy <= 1'b0;
            homing_profile <= 1'b0;
        end else begin
            if (homing_complete) begin
                homed <= 1'b1;
                home_busy <= 1'b0;
            end else if (soft_clear) begin
                homed <= 1'b0;
                home_busy <= 1'b0;
            end else if (home_req) begin
                homed <= 1'b0;
                home_busy <= 1'b1;
                homing_profile <= ctrl[`CPCH_BIT_PROFILE];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            homing_start <= 1'b0;
            multiturn_clear <= 1'b0;
        end else begin
            homing_start <= home_req;
            multiturn_clear <= mt_req;
        end
    end

    // Reply
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reply <= '0;
            last_err <= `CPCH_ERR_NONE;
        end else if (eval) begin
            reply.actual_position <= actual_position;
            if (!crc_q) begin
                reply.code <= `CPCH_RSP_COMM;
                reply.err <= `CPCH_ERR_NONE;
                reply.sub_hdr <= `CPCH_SUB_HDR_COMM;
            end else begin
                reply.code <= {1'b0, cmd_q.code};
                reply.sub_hdr <= {cmd_q.sub.valid, 3'h0, cmd_q.sub.code};
                if (ev_range) begin
                    reply.err <= `CPCH_ERR_RANGE;
                    last_err <= `CPCH_ERR_RANGE;
                end else if (ev_move) begin
                    reply.err <= `CPCH_ERR_MOVE;
                    last_err <= `CPCH_ERR_MOVE;
                end else if (refuse) begin
                    reply.err <= `CPCH_ERR_HOME;
                    last_err <= `CPCH_ERR_HOME;
                end else if (cmd_q.cyc == `CPCH_CYC_POS && pos_mode && !home_gate_ok) begin
                    reply.err <= `CPCH_ERR_NOHOME;
                    last_err <= `CPCH_ERR_NOHOME;
                end else begin
                    reply.err <= `CPCH_ERR_NONE;
                end
            end
        end
    end

    assign reply_valid = state == CPCH_ST_REPLY;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sub_valid <= 1'b0;
            sub_request <= '0;
        end else begin
            sub_valid <= eval && crc_q && cmd_q.sub.valid;
            if (eval && crc_q && cmd_q.sub.valid) begin
                sub_request <= cmd_q.sub;
            end
        end
    end

    // Sticky status; a set in the clearing cycle wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_move <= 1'b0;
            st_wrap <= 1'b0;
            st_range <= 1'b0;
            st_crc <= 1'b0;
            st_refuse <= 1'b0;
        end else begin
            if (bus_wr && avs_address == `CPCH_OFS_STATUS) begin
                st_move <= st_move && !avs_writedata[1];
                st_wrap <= st_wrap && !avs_writedata[2];
                st_range <= st_range && !avs_writedata[3];
                st_crc <= st_crc && !avs_writedata[4];
                st_refuse <= st_refuse && !avs_writedata[5];
            end
            if (ev_move) begin
                st_move <= 1'b1;
            end
            if (take && !range_bad && wrap) begin
                st_wrap <= 1'b1;
            end
            if (ev_range) begin
                st_range <= 1'b1;
            end
            if (ev_crc) begin
                st_crc <= 1'b1;
            end
            if (refuse) begin
                st_refuse <= 1'b1;
            end
        end
    end

    // Bus: one wait cycle, write lands when waitrequest is low
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack) begin
            case (avs_address)
                `CPCH_OFS_CTRL: avs_readdata <= {26'h0, ctrl[5:0]};
                `CPCH_OFS_STATUS: avs_readdata <= {26'h0, st_refuse, st_crc, st_range, st_wrap, st_move, homed};
                `CPCH_OFS_LIMIT: avs_readdata <= move_limit;
                `CPCH_OFS_RMIN: avs_readdata <= range_min;
                `CPCH_OFS_RMAX: avs_readdata <= range_max;
                `CPCH_OFS_COMMANDED_POSITION: avs_readdata <= target_position;
                `CPCH_OFS_LERR: avs_readdata <= {16'h0, last_err};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // Reset and validation bits pulse only; they never read back
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= `CPCH_RST_CTRL;
            move_limit <= `CPCH_RST_LIMIT;
            range_min <= `CPCH_RST_RMIN;
            range_max <= `CPCH_RST_RMAX;
        end else if (bus_wr) begin
            case (avs_address)
                `CPCH_OFS_CTRL: ctrl <= {26'h0, avs_writedata[5:0]};
                `CPCH_OFS_LIMIT: move_limit <= avs_writedata;
                `CPCH_OFS_RMIN: range_min <= avs_writedata;
                `CPCH_OFS_RMAX: range_max <= avs_writedata;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_crc_reply_code: assert property (ev_crc |=> reply_valid && reply.code == `CPCH_RSP_COMM)
        else $error("bad checksum frame not answered with FFh");
    a_crc_keeps_target: assert property (ev_crc |=> target_position == $past(target_position))
        else $error("target moved on bad checksum frame");
    a_idle_keeps_target: assert property (eval && crc_q && cmd_q.cyc == `CPCH_CYC_IDLE
        |=> $stable(target_position))
        else $error("target moved on idle command");
    a_range_error: assert property (ev_range |=> reply.err == `CPCH_ERR_RANGE && st_range
        && $stable(target_position))
        else $error("out of range position not refused with 0033h");
    a_move_limit: assert property (ev_move |=> st_move && reply.err == `CPCH_ERR_MOVE)
        else $error("movement limit breach not flagged");
    a_pos_apply: assert property (take && !range_bad && !over_limit
        |=> target_position == 32'($past(target_position) + $past(delta)))
        else $error("accepted position not applied");
    a_home_refused: assert property (refuse |=> !homing_start ##1 !homing_start)
        else $error("homing started in velocity or torque mode");
    // Enable is registered, so it answers to the gate of the cycle before
    a_home_gate: assert property (position_enable
        |-> $past(homed) || !$past(incremental) || $past(home_busy))
        else $error("positioning enabled before homing");
    a_frame_reply: assert property (state == CPCH_ST_WAIT && frame_valid |-> ##2 reply_valid)
        else $error("frame reply not produced in two cycles");
    a_bus_wait: assert property ((avs_read || avs_write) && !ack |=> !avs_waitrequest)
        else $error("bus request held longer than one wait cycle");

    c_position_taken: cover property (take && !range_bad && !over_limit && servo_active);
    c_crc_error: cover property (ev_crc ##2 frame_valid);
    c_homing: cover property (home_req ##[1:50] homing_complete);
    c_wrap: cover property (take && wrap && !over_limit);
endmodule : cpch_handler
`default_nettype wire

// *** cpch_host_model.sv ***
// Host controller model: sends one command frame for each call.
// Assumes ref_clk drives the handler and the caller keeps frames 3 cycles apart.
`timescale 1ns/1ns
`default_nettype none
module cpch_host_model (
    // Clock and drive state
    input wire logic ref_clk,
    input wire logic servo_active,
    input wire logic [31:0] actual_position,
    // Frame out
    output logic frame_valid,
    output logic frame_crc_ok,
    output logic [255:0] frame_data
);
    initial begin
        frame_valid = 1'b0;
        frame_crc_ok = 1'b0;
        frame_data = '0;
    end
    // Caller gives small steps, lone idle frames, trajectory kept on bad checksum
    task automatic send(input logic [255:0] f, input logic ok);
        @(posedge ref_clk);
        if (servo_active !== 1'b1) begin
            f[63:32] = actual_position;
        end
        frame_data <= f;
        frame_crc_ok <= ok;
        frame_valid <= 1'b1;
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        // Stale bytes inverted so a late sample cannot match
        frame_data <= ~f;
        frame_crc_ok <= ~ok;
    endtask : send
endmodule : cpch_host_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the cyclic position command handler.
// Assumes the host model as frame source and Avalon-MM access through tasks.
`timescale 1ns/1ns
`default_nettype none
module tb import cpch_pkg::*;;
    logic ref_clk = 1'b0, sys_rst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic avs_waitrequest, frame_valid, frame_crc_ok;
    logic [255:0] frame_data;
    logic servo_active = 1'b1, homing_complete = 1'b0;
    logic [31:0] actual_position = 32'h0, target_position;
    logic reply_valid, position_enable, homing_start, homing_profile, multiturn_clear, sub_valid;
    cpch_reply_t reply;
    cpch_sub_t sub_request;
    int errors = 0, checks_done = 0, cycles = 0;
    cpch_handler dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_valid(frame_valid),
        .frame_crc_ok(frame_crc_ok), .frame_data(frame_data), .servo_active(servo_active),
        .actual_position(actual_position), .homing_complete(homing_complete),
        .reply_valid(reply_valid), .reply(reply), .target_position(target_position),
        .position_enable(position_enable), .homing_start(homing_start),
        .homing_profile(homing_profile), .multiturn_clear(multiturn_clear),
        .sub_valid(sub_valid), .sub_request(sub_request));
    cpch_host_model host (.ref_clk(ref_clk), .servo_active(servo_active),
        .actual_position(actual_position), .frame_valid(frame_valid),
        .frame_crc_ok(frame_crc_ok), .frame_data(frame_data));
    always #10 ref_clk = ~ref_clk;
    task automatic final_report();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    // Ceiling far above the roughly 120 cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        // Sampled at the edge itself, before the slave's updates land
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 50) begin
            errors++;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : acc
    task automatic rchk(input logic [2:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rchk
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    function automatic logic [255:0] mk(input logic [7:0] c, input logic [31:0] p, input logic [7:0] ty);
        mk = '0;
        mk[15:8] = c;
        mk[63:32] = p;
        mk[71:64] = ty;
    endfunction : mk
    // Returns one ns into the reply cycle, where registered outputs are settled
    task automatic fr(input logic [255:0] f, input logic ok);
        int n;
        n = 0;
        host.send(f, ok);
        while (reply_valid !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(32'(reply_valid), 32'h1);
    endtask : fr
    task automatic s_regs();
        rchk(3'h0, 32'h0);
        rchk(3'h2, 32'h00100000);
        rchk(3'h3, 32'h0);
        rchk(3'h4, 32'h000FFFFF);
        wr(3'h5, 32'hFFFFFFFF);
        rchk(3'h5, 32'h0);
        wr(3'h7, 32'hFFFFFFFF);
        rchk(3'h7, 32'h0);
    endtask : s_regs
    task automatic s_pos();
        fr(mk(8'h20, 32'h100, 8'h0), 1'b1);
        chk(target_position, 32'h100);
        chk(32'(reply.err), 32'h0);
        fr(mk(8'h20, 32'h80, 8'h0), 1'b1);
        chk(target_position, 32'h80);
        fr(mk(8'h00, 32'h5555, 8'h0), 1'b1);
        chk(target_position, 32'h80);
        fr(mk(8'h20, 32'h9999, 8'h0), 1'b0);
        chk(32'(reply.code), 32'hFF);
        chk(32'(reply.sub_hdr), 32'h8F);
        chk(target_position, 32'h80);
    endtask : s_pos
    task automatic s_move();
        fr(mk(8'h20, 32'h00100081, 8'h0), 1'b1);
        chk(32'(reply.err), 32'h0274);
        chk(target_position, 32'h80);
        rchk(3'h1, 32'h12);
        wr(3'h1, 32'h3E);
        wr(3'h2, 32'hFFFFFFFF);
        fr(mk(8'h20, 32'h08100081, 8'h0), 1'b1);
        chk(target_position, 32'h08000080);
        rchk(3'h1, 32'h04);
    endtask : s_move
    task automatic s_range();
        wr(3'h0, 32'h10);
        fr(mk(8'h20, 32'h00100000, 8'h0), 1'b1);
        chk(32'(reply.err), 32'h0033);
        chk(target_position, 32'h08000080);
    endtask : s_range
    task automatic s_servo();
        logic [255:0] f;
        wr(3'h0, 32'h20);
        @(posedge ref_clk);
        servo_active <= 1'b0;
        actual_position <= 32'h1234;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(32'(position_enable), 32'h0);
        @(posedge ref_clk);
        servo_active <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(32'(position_enable), 32'h1);
        chk(target_position, 32'h08000080);
        f = mk(8'h20, 32'h08100081, 8'h0);
        f[135:128] = 8'h8A;
        f[143:136] = 8'h5A;
        f[159:144] = 16'h1234;
        f[191:160] = 32'hCAFE0001;
        fr(f, 1'b1);
        chk(32'(sub_valid), 32'h1);
        chk(reply.actual_position, 32'h00001234);
        chk(32'(reply.sub_hdr), 32'h8A);
        chk(32'(sub_request.index), 32'h1234);
        chk(32'(sub_request.sub_type), 32'h5A);
        chk(sub_request.sub_request_word1, 32'hCAFE0001);
    endtask : s_servo
    task automatic s_home();
        wr(3'h0, 32'h2);
        fr(mk(8'h24, 32'h0, 8'h0), 1'b1);
        chk(32'(reply.err), 32'h0010);
        fr(mk(8'h24, 32'h0, 8'h31), 1'b1);
        chk(32'(multiturn_clear), 32'h1);
        wr(3'h0, 32'h8);
        fr(mk(8'h20, 32'h08100081, 8'h0), 1'b1);
        chk(32'(reply.err), 32'h0011);
        wr(3'h0, 32'hC);
        fr(mk(8'h24, 32'h08100081, 8'h11), 1'b1);
        chk(32'(homing_start), 32'h1);
        chk(32'(homing_profile), 32'h1);
        @(posedge ref_clk);
        homing_complete <= 1'b1;
        @(posedge ref_clk);
        homing_complete <= 1'b0;
        wr(3'h1, 32'h3E);
        rchk(3'h1, 32'h01);
        fr(mk(8'h20, 32'h08100091, 8'h0), 1'b1);
        chk(target_position, 32'h08000090);
        wr(3'h0, 32'h4C);
        rchk(3'h1, 32'h0);
    endtask : s_home
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        s_regs();
        s_pos();
        s_move();
        s_range();
        s_servo();
        s_home();
        final_report();
    end
endmodule : tb
`default_nettype wire
